// >>> rotl_loader.sv
// Summary of operation
// RQ1 - cpu is held off until every loaded value is in place after reset.
// RQ2 - the option byte at its fixed address is read during the sequence.
// RQ3 - timeout rate gets the inverse of option bits 2..0.
// RQ4 - window mode gets the inverse of option bit 3.
// RQ5 - the supply-referenced bandgap result is read at its fixed halfword.
// RQ6 - the pin-referenced bandgap result is read at the next halfword.
// RQ7 - clock and temp trims share one halfword, tc and osc trims the next.
// RQ8 - each bandgap value is a left-justified 12-bit result.
// RQ9 - each bandgap value is an average of eight production conversions.
`timescale 1ns/100ps
module rotl_loader
  import rotl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  output rotl_flash_req_t flash_req,
  input wire logic flash_ack,
  input wire logic [DATA_W-1:0] flash_rdata,
  output logic cpu_hold,
  output rotl_wdog_t wdog_cfg,
  output rotl_trim_t trim_cfg,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic [7:0] reg_off(input logic [31:0] a);
    reg_off = {a[7:2], 2'b00};
  endfunction : reg_off

  function automatic logic reg_hit(input logic [7:0] o);
    reg_hit = (o <= REG_CTRL);
  endfunction : reg_hit

  rotl_state_t state_q, state_d;
  rotl_wdog_t wdog_q;
  rotl_trim_t trim_q;
  logic [DATA_W-1:0] ref_supply_q, ref_pins_q;
  logic reload_q;

  // sequencer
  wire step = flash_ack && state_q != ST_DONE;
  always_comb begin
    state_d = state_q;
    if (reload_q) state_d = ST_OPT;
    else if (step) begin
      unique case (state_q)
        ST_OPT: state_d = ST_REF0;
        ST_REF0: state_d = ST_REF1;
        ST_REF1: state_d = ST_CLK;
        ST_CLK: state_d = ST_OSC;
        ST_OSC: state_d = ST_DONE;
        ST_DONE: state_d = ST_DONE;
      endcase
    end
  end

  logic [ADDR_W-1:0] addr_sel;
  always_comb begin
    unique case (state_q)
      ST_OPT: addr_sel = OPTION_BYTE_ADDR; // RQ2
      ST_REF0: addr_sel = REF_SUPPLY_ADDR; // RQ5
      ST_REF1: addr_sel = REF_PINS_ADDR; // RQ6
      ST_CLK: addr_sel = CLK_TRIM_ADDR; // RQ7
      ST_OSC: addr_sel = OSC_TRIM_ADDR; // RQ7
      default: addr_sel = '0;
    endcase
  end
  assign flash_req.addr = addr_sel;
  assign flash_req.req = (state_q != ST_DONE);
  assign cpu_hold = (state_q != ST_DONE); // RQ1

  always_ff @(posedge aclk) begin
    if (!aresetn) state_q <= ST_OPT;
    else if (clk_en) state_q <= state_d;
  end

  // option decode
  wire [2:0] nv_rate = flash_rdata[OPT_RATE_LSB +: 3];
  wire nv_win = flash_rdata[OPT_WIN_BIT];
  wire cap_opt = clk_en && step && state_q == ST_OPT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog_q.timeout_rate_select <= RATE_RST;
      wdog_q.window_mode_select <= WIN_RST;
    end else if (cap_opt) begin
      wdog_q.timeout_rate_select <= ~nv_rate; // RQ3
      wdog_q.window_mode_select <= ~nv_win; // RQ4
    end
  end

  // reference results and trims
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_supply_q <= '0;
      ref_pins_q <= '0;
      trim_q <= '0;
    end else if (clk_en && step) begin
      unique case (state_q)
        ST_REF0: ref_supply_q <= flash_rdata; // RQ5 RQ8 RQ9
        ST_REF1: ref_pins_q <= flash_rdata; // RQ6 RQ8 RQ9
        ST_CLK: begin
          trim_q.autonomous_clock_trim <= flash_rdata[ACLK_LSB +: 6]; // RQ7
          trim_q.high_temp_trim <= flash_rdata[HTT_LSB +: 4]; // RQ7
        end
        ST_OSC: begin
          trim_q.temp_coefficient_trim <= flash_rdata[TC_LSB +: 5]; // RQ7
          trim_q.internal_osc_trim <= flash_rdata[IRC_LSB +: 10]; // RQ7
        end
        default: ;
      endcase
    end
  end
  assign wdog_cfg = wdog_q;
  assign trim_cfg = trim_q;

  // axi4-lite slave
  logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
  logic [7:0] aw_off_q;
  logic [31:0] wdata_q, rdata_q;
  logic [1:0] bresp_q, rresp_q;

  // handshakes only while enabled, so no beat is lost when frozen
  assign s_axi_awready = clk_en && !aw_got_q && !bvalid_q;
  assign s_axi_wready = clk_en && !w_got_q && !bvalid_q;
  assign s_axi_arready = clk_en && !rvalid_q;
  assign s_axi_bvalid = clk_en && bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = clk_en && rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_got_q || aw_fire;
  wire w_have = w_got_q || w_fire;
  wire [7:0] aw_off = aw_got_q ? aw_off_q : reg_off(s_axi_awaddr);
  wire [31:0] wdat = w_got_q ? wdata_q : s_axi_wdata;
  wire [3:0] wstrb_eff = s_axi_wstrb;
  wire wr_do = clk_en && aw_have && w_have && !bvalid_q;
  wire wr_ctrl = wr_do && aw_off == REG_CTRL && wdat[0] && wstrb_eff[0];

  wire [7:0] ar_off = reg_off(s_axi_araddr);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (ar_off)
      REG_WDOG: rd_mux = {28'h0, wdog_q.window_mode_select,
        wdog_q.timeout_rate_select};
      REG_CLKTRIM: rd_mux = {22'h0, trim_q.autonomous_clock_trim,
        trim_q.high_temp_trim};
      REG_OSCTRIM: rd_mux = {17'h0, trim_q.temp_coefficient_trim,
        trim_q.internal_osc_trim};
      REG_REFS: rd_mux = {ref_pins_q, ref_supply_q};
      REG_STATUS: rd_mux = {28'h0, 1'b0, state_q};
      default: rd_mux = '0;
    endcase
    if (ar_off == REG_STATUS) rd_mux[4] = (state_q == ST_DONE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_off_q <= '0;
      wdata_q <= '0;
      bresp_q <= 2'h0;
      reload_q <= 1'b0;
    end else if (clk_en) begin
      reload_q <= wr_ctrl && !cpu_hold;
      if (aw_fire) aw_off_q <= reg_off(s_axi_awaddr);
      if (w_fire) wdata_q <= s_axi_wdata;
      if (wr_do) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (aw_off == REG_CTRL) ? 2'h0 : 2'h2;
      end else begin
        if (aw_fire) aw_got_q <= 1'b1;
        if (w_fire) w_got_q <= 1'b1;
        if (bvalid_q && s_axi_bready) bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= 2'h0;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= reg_hit(ar_off) ? 2'h0 : 2'h2;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule : rotl_loader

// >>> rotl_pkg.sv
package rotl_pkg;
  // flash geometry
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OPTION_BYTE_ADDR = 24'hfffe0e;
  localparam logic [ADDR_W-1:0] REF_SUPPLY_ADDR = 24'h1fc040;
  localparam logic [ADDR_W-1:0] REF_PINS_ADDR = 24'h1fc042;
  localparam logic [ADDR_W-1:0] CLK_TRIM_ADDR = 24'h1fc0b8;
  localparam logic [ADDR_W-1:0] OSC_TRIM_ADDR = 24'h1fc0ba;
  // field positions in the option byte
  localparam int OPT_RATE_LSB = 0;
  localparam int OPT_WIN_BIT = 3;
  // field positions in trim halfwords
  localparam int ACLK_LSB = 10;
  localparam int HTT_LSB = 0;
  localparam int TC_LSB = 10;
  localparam int IRC_LSB = 0;
  // left-justified 12-bit reference
  localparam int REF_LSB = 4;
  localparam int REF_AVG_COUNT = 8;
  // register offsets
  localparam logic [7:0] REG_WDOG = 8'h00;
  localparam logic [7:0] REG_CLKTRIM = 8'h04;
  localparam logic [7:0] REG_OSCTRIM = 8'h08;
  localparam logic [7:0] REG_REFS = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  // reset values
  localparam logic [2:0] RATE_RST = 3'h0;
  localparam logic WIN_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_OPT, ST_REF0, ST_REF1, ST_CLK, ST_OSC, ST_DONE
  } rotl_state_t;

  typedef struct packed {
    logic [2:0] timeout_rate_select;
    logic window_mode_select;
  } rotl_wdog_t;

  typedef struct packed {
    logic [5:0] autonomous_clock_trim;
    logic [3:0] high_temp_trim;
    logic [4:0] temp_coefficient_trim;
    logic [9:0] internal_osc_trim;
  } rotl_trim_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic req;
  } rotl_flash_req_t;
endpackage : rotl_pkg

// >>> rotl_flash_model.sv
`timescale 1ns/100ps
module rotl_flash_model
  import rotl_pkg::*;
(
  input wire logic aclk,
  input rotl_flash_req_t flash_req,
  input wire logic [7:0] opt,
  input wire logic slow,
  output logic flash_ack = 1'b0,
  output logic [DATA_W-1:0] flash_rdata = 16'h0
);
  logic [DATA_W-1:0] word;
  logic [1:0] wait_q = 2'h0;
  wire go = flash_req.req && !flash_ack && (!slow || wait_q == 2'h3);
  always_comb begin
    case (flash_req.addr)
      OPTION_BYTE_ADDR: word = {8'hff, opt};
      REF_SUPPLY_ADDR: word = 16'h5a30;
      REF_PINS_ADDR: word = 16'h7c10;
      CLK_TRIM_ADDR: word = 16'hb40d;
      OSC_TRIM_ADDR: word = 16'h56a7;
      default: word = 16'hdead;
    endcase
  end
  always_ff @(posedge aclk) begin
    wait_q <= (flash_req.req && !flash_ack) ? wait_q + 2'h1 : 2'h0;
    flash_ack <= go;
    flash_rdata <= go ? word : ~flash_rdata;
  end
endmodule : rotl_flash_model

// >>> rotl_loader_sva.sv
`timescale 1ns/100ps
module rotl_loader_sva
  import rotl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input rotl_flash_req_t flash_req,
  input wire logic flash_ack,
  input wire logic [DATA_W-1:0] flash_rdata,
  input wire logic cpu_hold,
  input rotl_wdog_t wdog_cfg,
  input rotl_trim_t trim_cfg
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [DATA_W-1:0] rd_q;
  wire tk = clk_en && flash_ack && flash_req.req;
  wire t_opt = tk && flash_req.addr == OPTION_BYTE_ADDR;
  wire t_sup = tk && flash_req.addr == REF_SUPPLY_ADDR;
  wire t_clk = tk && flash_req.addr == CLK_TRIM_ADDR;
  wire t_osc = tk && flash_req.addr == OSC_TRIM_ADDR;
  always_ff @(posedge aclk) begin
    rd_q <= flash_rdata;
  end
  hold_while_load_a: assert property (cpu_hold == flash_req.req)
    else $error("cpu hold differs from load");
  hold_release_a: assert property ($fell(cpu_hold) |-> $past(t_osc))
    else $error("cpu released before last trim");
  first_addr_a: assert property ($rose(aresetn) |->
    flash_req.addr == OPTION_BYTE_ADDR) else $error("bad first address");
  rate_inverse_a: assert property (t_opt |=>
    wdog_cfg.timeout_rate_select == ~rd_q[2:0]) else $error("bad rate");
  window_inverse_a: assert property (t_opt |=>
    wdog_cfg.window_mode_select == ~rd_q[3]) else $error("bad window");
  supply_ref_a: assert property (t_opt |=>
    flash_req.addr == REF_SUPPLY_ADDR) else $error("bad second address");
  pin_ref_a: assert property (t_sup |=>
    flash_req.addr == REF_PINS_ADDR) else $error("bad third address");
  clock_trim_a: assert property (t_clk |=>
    trim_cfg.autonomous_clock_trim == rd_q[15:10] &&
    trim_cfg.high_temp_trim == rd_q[3:0]) else $error("bad clock trim");
  osc_trim_a: assert property (t_osc |=>
    trim_cfg.temp_coefficient_trim == rd_q[14:10] &&
    trim_cfg.internal_osc_trim == rd_q[9:0] && !cpu_hold)
    else $error("bad oscillator trim");
endmodule : rotl_loader_sva
bind rotl_loader rotl_loader_sva i_rotl_loader_sva (.*);

// >>> reset_option_trim_loader_bench.sv
`timescale 1ns/100ps
module reset_option_trim_loader_bench
  import rotl_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, slow = 1'b0;
  logic flash_ack, cpu_hold, s_axi_bvalid, s_axi_rvalid;
  logic [7:0] opt = 8'h00;
  logic [DATA_W-1:0] flash_rdata;
  rotl_flash_req_t flash_req;
  rotl_wdog_t wdog_cfg;
  rotl_trim_t trim_cfg;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_count = 0, checks = 0;
  rotl_loader i_rotl_loader (.*);
  rotl_flash_model i_rotl_flash_model (.*);
  initial forever #10 aclk = ~aclk;
  always @(posedge aclk) clk_en <= ~clk_en | ~slow;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, e);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, e);
  endtask : axr
  task automatic wait_done;
    for (int n = 0; n < 20 && cpu_hold !== 1'b1; n++) @(posedge aclk);
    for (int n = 0; n < 300 && cpu_hold !== 1'b0; n++) @(posedge aclk);
    chk(cpu_hold, 1'b0);
  endtask : wait_done
  task automatic t_reset_load;
    chk(cpu_hold, 1'b1);
    chk(flash_req.addr, OPTION_BYTE_ADDR);
    aresetn <= 1'b1;
    wait_done();
    chk(trim_cfg, {6'h2d, 4'hd, 5'h15, 10'h2a7});
    axr(REG_REFS, 32'h7c105a30, 2'h0);
    axr(REG_CLKTRIM, 32'h2dd, 2'h0);
    axr(REG_OSCTRIM, 32'h56a7, 2'h0);
  endtask : t_reset_load
  task automatic t_codes;
    for (int i = 0; i < 16; i++) begin
      opt <= 8'(i) | 8'hf0;
      slow <= i[0];
      axw(REG_CTRL, 32'h1, 2'h0);
      wait_done();
      chk(wdog_cfg, {~opt[2:0], ~opt[3]});
      axr(REG_WDOG, {28'h0, ~opt[3], ~opt[2:0]}, 2'h0);
    end
  endtask : t_codes
  task automatic t_refuse;
    axw(REG_WDOG, 32'h0, 2'h2);
    axr(8'h20, 32'h0, 2'h2);
    axr(REG_CTRL, 32'h0, 2'h0);
    chk(wdog_cfg, {~opt[2:0], ~opt[3]});
  endtask : t_refuse
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge aclk);
    t_reset_load();
    t_codes();
    t_refuse();
    final_report();
  end
endmodule : reset_option_trim_loader_bench
